// File: verilog/nmu_pkg.sv
// Purpose: Constants and carrier types of the non-maskable interrupt unit
// Assumes: 32-bit core, AXI4-Lite register port with 8-bit byte addresses
// Notes:   Shared by the unit and its bench
package nmu_pkg;

  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_RISE_SEL = 8'h00;
  localparam logic [7:0] OFF_FALL_SEL = 8'h04;
  localparam logic [7:0] OFF_WDT_MODE = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_PSW = 8'h10;
  localparam logic [7:0] OFF_PC_SAVE = 8'h14;
  localparam logic [7:0] OFF_PSW_SAVE = 8'h18;
  localparam logic [7:0] OFF_CAUSE = 8'h1C;

  // ----------------------------------------------------------------
  // Fields and values
  // ----------------------------------------------------------------
  localparam int PSW_ID_BIT = 5;
  localparam int PSW_EP_BIT = 6;
  localparam int PSW_NP_BIT = 7;
  localparam int NMI_EDGE_BIT = 0;
  localparam logic [1:0] WDT_MODE_NMI = 2'h2;
  localparam logic [15:0] NMI_CAUSE = 16'h0010;
  localparam logic [31:0] NMI_HANDLER = 32'h0000_0010;
  localparam logic [31:0] PSW_RESET = 32'h0000_0000;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic accept_ok;
    logic [31:0] restored_pc;
    logic div_active;
    logic [31:0] div_pc;
    logic return_from_trap;
    logic sreg_load;
    logic [31:0] sreg_data;
  } nmu_core_in_t;

  typedef struct packed {
    logic redirect_valid;
    logic [31:0] redirect_pc;
    logic [31:0] program_status_word;
    logic [31:0] nmi_pc_save;
    logic [31:0] nmi_status_save;
    logic [31:0] exception_cause_reg;
    logic maskable_allow;
  } nmu_core_out_t;

endpackage

// File: verilog/nmu_unit.sv
// Purpose: Non-maskable interrupt acceptance, context save and restore
// Assumes: Core samples redirect on the cycle it is high
// Notes:   All state sits in one struct registered under ce
`timescale 1ns/10ps
`default_nettype none

module nmu_unit
  import nmu_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic nmi_pin,
  input wire logic watchdog_nmi_request,
  input wire nmu_core_in_t core_in,
  output nmu_core_out_t core_out
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr
    $error("ADDR_W must lie between 5 and 8");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic pend_pin;
    logic pend_wdt;
    logic in_svc;
    logic [7:0] rise_sel;
    logic [7:0] fall_sel;
    logic [7:0] wdt_mode;
    nmu_core_out_t co;
    logic aw_h;
    logic w_h;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } nmu_state_t;

  nmu_state_t st;
  nmu_state_t next_st;
  logic np;
  logic take_pin;
  logic take_wdt;
  logic take_any;
  logic return_from_trap_ok;
  logic [31:0] save_pc;
  logic pin_edge;
  logic wdt_arm;

  // Byte lane 0 merge; bit access is done by software read-modify-write
  function automatic logic [7:0] merge8(input logic [7:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
    merge8 = s[0] ? d[7:0] : old;
  endfunction

  // Word merge under byte enables
  function automatic logic [31:0] merge32(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    merge32 = r;
  endfunction

  // ----------------------------------------------------------------
  // Acceptance decisions
  // ----------------------------------------------------------------
  assign np = st.co.program_status_word[PSW_NP_BIT];
  assign pin_edge = (st.s2 & ~st.s3 & st.rise_sel[NMI_EDGE_BIT]) |
                    (~st.s2 & st.s3 & st.fall_sel[NMI_EDGE_BIT]);
  assign wdt_arm = watchdog_nmi_request &
                   (st.wdt_mode[1:0] == WDT_MODE_NMI);
  // inhibit flag ignored, service blocks pin
  assign take_pin = ce & core_in.accept_ok & ~core_in.return_from_trap &
                    st.pend_pin & ~st.in_svc & ~np;
  // pin first, watchdog blocked only by flag
  assign take_wdt = ce & core_in.accept_ok & ~core_in.return_from_trap &
                    st.pend_wdt & ~np & ~take_pin;
  assign take_any = take_pin | take_wdt;
  // return only when trap-level 0 and active 1
  assign return_from_trap_ok = ce & core_in.return_from_trap &
                   ~st.co.program_status_word[PSW_EP_BIT] & np;
  // division restarts from its own address
  assign save_pc = core_in.div_active ? core_in.div_pc
                                      : core_in.restored_pc;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] wa;
    logic [7:0] ra;
    logic [31:0] rd;
    logic hit;
    wa = 8'(st.awaddr);
    ra = 8'(s_axi_araddr);
    rd = 32'h0000_0000;
    hit = 1'b1;
    next_st = st;
    next_st.s1 = nmi_pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.co.redirect_valid = 1'b0;
    // pending until taken, new edge wins
    if (take_pin) begin
      next_st.pend_pin = 1'b0;
    end
    if (pin_edge) begin
      next_st.pend_pin = 1'b1;
    end
    if (take_wdt) begin
      next_st.pend_wdt = 1'b0;
    end
    if (wdt_arm) begin
      next_st.pend_wdt = 1'b1;
    end
    // Core status word load; acceptance below overrides it
    if (core_in.sreg_load) begin
      next_st.co.program_status_word = core_in.sreg_data;
    end
    if (take_any) begin
      next_st.co.nmi_pc_save = save_pc;
      next_st.co.nmi_status_save = st.co.program_status_word;
      next_st.co.exception_cause_reg[31:16] = NMI_CAUSE;
      next_st.co.program_status_word = st.co.program_status_word;
      next_st.co.program_status_word[PSW_NP_BIT] = 1'b1;
      next_st.co.program_status_word[PSW_ID_BIT] = 1'b1;
      next_st.co.program_status_word[PSW_EP_BIT] = 1'b0;
      next_st.co.redirect_valid = 1'b1;
      next_st.co.redirect_pc = NMI_HANDLER;
      next_st.in_svc = 1'b1;
    end else if (return_from_trap_ok) begin
      next_st.co.program_status_word = st.co.nmi_status_save;
      next_st.co.redirect_valid = 1'b1;
      next_st.co.redirect_pc = st.co.nmi_pc_save;
      next_st.in_svc = 1'b0;
    end
    // maskable only when active and inhibit flags clear and nothing pending
    next_st.co.maskable_allow =
      ~next_st.co.program_status_word[PSW_NP_BIT] &
      ~next_st.co.program_status_word[PSW_ID_BIT] &
      ~next_st.pend_pin & ~next_st.pend_wdt;

    // AXI write channel capture, address and data in either order
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_h = 1'b1;
      next_st.awaddr = 8'(s_axi_awaddr);
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_h = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.aw_h && st.w_h && !st.bvalid) begin
      next_st.aw_h = 1'b0;
      next_st.w_h = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      unique case ({wa[7:2], 2'b00})
        // byte lane access of select registers
        OFF_RISE_SEL:
          next_st.rise_sel = merge8(st.rise_sel, st.wdata, st.wstrb);
        OFF_FALL_SEL:
          next_st.fall_sel = merge8(st.fall_sel, st.wdata, st.wstrb);
        OFF_WDT_MODE:
          next_st.wdt_mode = merge8(st.wdt_mode, st.wdata, st.wstrb);
        OFF_CAUSE: begin
          next_st.co.exception_cause_reg =
            merge32(st.co.exception_cause_reg, st.wdata, st.wstrb);
          // entry in the same cycle beats the software write
          if (take_any) begin
            next_st.co.exception_cause_reg[31:16] = NMI_CAUSE;
          end
        end
        OFF_STATUS, OFF_PSW, OFF_PC_SAVE, OFF_PSW_SAVE: begin
          // Read-only words; write ignored
        end
        default: next_st.bresp = RESP_DECERR;
      endcase
    end
    next_st.awready = ~next_st.aw_h & ~next_st.bvalid;
    next_st.wready = ~next_st.w_h & ~next_st.bvalid;

    // AXI read channel, one cycle to answer
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st.arready) begin
      unique case ({ra[7:2], 2'b00})
        OFF_RISE_SEL: rd = {24'h00_0000, st.rise_sel};
        OFF_FALL_SEL: rd = {24'h00_0000, st.fall_sel};
        OFF_WDT_MODE: rd = {24'h00_0000, st.wdt_mode};
        OFF_STATUS: rd = {29'h0, st.in_svc, st.pend_wdt, st.pend_pin};
        OFF_PSW: rd = st.co.program_status_word;
        OFF_PC_SAVE: rd = st.co.nmi_pc_save;
        OFF_PSW_SAVE: rd = st.co.nmi_status_save;
        OFF_CAUSE: rd = st.co.exception_cause_reg;
        default: hit = 1'b0;
      endcase
      next_st.rvalid = 1'b1;
      next_st.rdata = rd;
      next_st.rresp = hit ? RESP_OKAY : RESP_DECERR;
    end
    next_st.arready = ~next_st.rvalid;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // edge selection starts at none
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.rise_sel <= SEL_RESET;
      st.fall_sel <= SEL_RESET;
      st.co.program_status_word <= PSW_RESET;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // Outputs straight from state
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign core_out = st.co;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // rising edge with rise bit pends
  a_rise_pends: assert property (ce && st.s2 && !st.s3 &&
    st.rise_sel[NMI_EDGE_BIT] |=> st.pend_pin)
    else $error("rising edge not made pending");
  // no edge chosen keeps pin quiet
  a_no_edge_quiet: assert property (!st.rise_sel[NMI_EDGE_BIT] &&
    !st.fall_sel[NMI_EDGE_BIT] && !st.pend_pin |=> !st.pend_pin)
    else $error("pin pended with no edge selected");
  a_wdt_mode_gate: assert property (ce && watchdog_nmi_request &&
    st.wdt_mode[1:0] != WDT_MODE_NMI && !st.pend_wdt
    |=> !st.pend_wdt)
    else $error("watchdog pended outside mode 2");
  a_pin_first: assert property (take_pin && st.pend_wdt
    |=> st.pend_wdt)
    else $error("watchdog lost when pin taken");
  a_pin_held: assert property (st.in_svc && st.pend_pin && !return_from_trap_ok
    |-> !take_pin ##1 st.pend_pin && st.in_svc)
    else $error("pin taken during service");
  // watchdog cuts in once flag cleared
  a_wdt_cut_in: assert property (ce && core_in.accept_ok &&
    !core_in.return_from_trap && st.pend_wdt && st.in_svc && !np
    |=> st.co.redirect_valid &&
        st.co.redirect_pc == NMI_HANDLER)
    else $error("watchdog not taken with flag clear");
  a_save_ctx: assert property (take_any |=>
    st.co.nmi_pc_save == $past(save_pc) &&
    st.co.nmi_status_save == $past(st.co.program_status_word))
    else $error("context not saved");
  a_entry_fx: assert property (take_any |=>
    st.co.exception_cause_reg[31:16] == NMI_CAUSE && np &&
    st.co.program_status_word[PSW_ID_BIT] &&
    !st.co.program_status_word[PSW_EP_BIT] &&
    st.co.redirect_valid && st.co.redirect_pc == NMI_HANDLER)
    else $error("entry effects wrong");
  a_return_from_trap_restore: assert property (return_from_trap_ok |=>
    st.co.program_status_word == $past(st.co.nmi_status_save) &&
    st.co.redirect_pc == $past(st.co.nmi_pc_save) &&
    !st.in_svc)
    else $error("return did not restore");
  a_mask_block: assert property (np |-> !st.co.maskable_allow ##1
    (!np || !st.co.maskable_allow))
    else $error("maskable allowed under active flag");

  c_pin_nmi: cover property (take_pin ##[1:40] return_from_trap_ok);
  c_both: cover property (take_pin && st.pend_wdt);
  c_wdt_cut: cover property (st.in_svc && !np && take_wdt);
  c_nested_pin: cover property (st.in_svc && pin_edge ##[1:40] take_pin);

endmodule // nmu_unit

`default_nettype wire

// File: verification/nmu_nmi_source.sv
// Purpose: Pin source and watchdog stand-in on the far side of the unit
// Assumes: Bench sets the pin level and toggles a fire request
// Notes:   Each toggle leaves as one watchdog pulse of one cycle
`timescale 1ns/10ps
`default_nettype none

module nmu_nmi_source (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin_level,
  input wire logic wdt_toggle,
  output logic nmi_pin,
  output logic watchdog_nmi_request
);
  logic last_toggle;

  // ----------------------------------------------------------------
  // Pin and watchdog pulse
  // ----------------------------------------------------------------
  // Registered so the pin moves just after an edge, like a real port;
  // a held watchdog level would re-arm pending, so only pulses leave
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi_pin <= 1'h0;
      watchdog_nmi_request <= 1'h0;
      last_toggle <= wdt_toggle;
    end else begin
      nmi_pin <= pin_level;
      watchdog_nmi_request <= wdt_toggle ^ last_toggle;
      last_toggle <= wdt_toggle;
    end
  end
endmodule // nmu_nmi_source

`default_nettype wire

// File: verification/nmu_unit_bench.sv
// Purpose: Self-checking bench of the non-maskable interrupt unit
// Assumes: 200 MHz clock; the bench plays the core and software
// Notes:   Bus handshakes are sampled at the rising edge
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  num_errors++; $display("unexpected %s exp %0h got %0h", n, e, g); end end

module nmu_unit_bench;
  import nmu_pkg::*;
  typedef struct packed {
    logic wr;
    logic [7:0] a;
    logic [31:0] d;
    logic [3:0] s;
    logic [1:0] r;
  } nmu_row_t;
  localparam nmu_row_t ROWS [17] = '{
    '{1'h0, 8'h00, 32'h0, 4'hF, RESP_OKAY},
    '{1'h0, 8'h04, 32'h0, 4'hF, RESP_OKAY},
    '{1'h0, 8'h08, 32'h0, 4'hF, RESP_OKAY},
    '{1'h0, 8'h0C, 32'h0, 4'hF, RESP_OKAY},
    '{1'h0, 8'h10, 32'h0, 4'hF, RESP_OKAY},
    '{1'h0, 8'h14, 32'h0, 4'hF, RESP_OKAY},
    '{1'h0, 8'h18, 32'h0, 4'hF, RESP_OKAY},
    '{1'h0, 8'h1C, 32'h0, 4'hF, RESP_OKAY},
    '{1'h0, 8'h20, 32'h0, 4'hF, RESP_DECERR},
    '{1'h1, 8'h20, 32'h1, 4'hF, RESP_DECERR},
    '{1'h1, 8'h10, 32'hFF, 4'hF, RESP_OKAY},
    '{1'h0, 8'h10, 32'h0, 4'hF, RESP_OKAY},
    '{1'h1, 8'h04, 32'hFF, 4'h1, RESP_OKAY},
    '{1'h0, 8'h04, 32'hFF, 4'hF, RESP_OKAY},
    '{1'h1, 8'h1C, 32'h12345678, 4'h3, RESP_OKAY},
    '{1'h0, 8'h1C, 32'h5678, 4'hF, RESP_OKAY},
    '{1'h1, 8'h04, 32'h0, 4'h1, RESP_OKAY}};
  logic aclk = 1'h0;
  logic aresetn, ce, pin_level, wdt_toggle, nmi_pin, watchdog_nmi_request;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, sel;
  nmu_core_in_t core_in;
  nmu_core_out_t core_out;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  nmu_unit u_dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nmi_pin,
    .watchdog_nmi_request, .core_in, .core_out);
  nmu_nmi_source u_src (.aclk, .aresetn, .pin_level, .wdt_toggle,
    .nmi_pin, .watchdog_nmi_request);

  // ----------------------------------------------------------------
  // Clock, hang guard and verdict
  // ----------------------------------------------------------------
  always #2.5 aclk = ~aclk;
  // A whole run needs under two thousand cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (num_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Bus master; holds each channel until its ready edge
  // ----------------------------------------------------------------
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [1:0] r);
    logic awh, wh;
    awh = 1'h0;
    wh = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    // Each channel drops right after the edge that saw its ready high
    do begin
      @(posedge aclk);
      if (!awh && s_axi_awready) begin
        awh = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!wh && s_axi_wready) begin
        wh = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end while (!(awh && wh));
    // Response follows both; taken at the edge that sees it
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, 4'hF, rsp);
    `CHK("bresp", RESP_OKAY, rsp)
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    axi_read(a, rd, rsp);
    `CHK("rdata", e, rd)
  endtask

  // ----------------------------------------------------------------
  // Core and software side
  // ----------------------------------------------------------------
  // Watches a window for a redirect; stops at the first one seen
  task automatic wait_take(input logic e, input logic [31:0] pc,
      input logic [31:0] sw);
    logic got;
    got = 1'h0;
    for (int i = 0; i < 16 && !got; i++) begin
      @(negedge aclk);
      if (core_out.redirect_valid === 1'h1) begin
        got = 1'h1;
        `CHK("redirect_pc", pc, core_out.redirect_pc)
        `CHK("status_word", sw, core_out.program_status_word)
      end
    end
    `CHK("taken", e, got)
  endtask
  task automatic check_entry(input logic [31:0] pcs, input logic [31:0] sws);
    `CHK("pc_save", pcs, core_out.nmi_pc_save)
    `CHK("status_save", sws, core_out.nmi_status_save)
    `CHK("cause", NMI_CAUSE, core_out.exception_cause_reg[31:16])
    `CHK("maskable_allow", 1'h0, core_out.maskable_allow)
  endtask
  // Flags are left as entry set them, so the return is honoured
  task automatic do_return(input logic [31:0] pc, input logic [31:0] sw);
    @(posedge aclk);
    core_in.return_from_trap <= 1'h1;
    @(posedge aclk);
    core_in.return_from_trap <= 1'h0;
    wait_take(1'h1, pc, sw);
  endtask
  task automatic sload(input logic [31:0] d);
    @(posedge aclk);
    core_in.sreg_load <= 1'h1;
    core_in.sreg_data <= d;
    @(posedge aclk);
    core_in.sreg_load <= 1'h0;
  endtask
  task automatic set_pin(input logic v, input logic fire);
    @(posedge aclk);
    pin_level <= v;
    if (fire) wdt_toggle <= ~wdt_toggle;
  endtask
  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'h0;
    pin_level <= 1'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {aresetn, pin_level, wdt_toggle, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr} = '0;
    {s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    ce = 1'h1;
    core_in = '0;
    core_in.accept_ok = 1'h1;
    core_in.restored_pc = 32'h100;
    do_reset();
    foreach (ROWS[i]) begin
      if (ROWS[i].wr) axi_write(ROWS[i].a, ROWS[i].d, ROWS[i].s, rsp);
      else axi_read(ROWS[i].a, rd, rsp);
      if (!ROWS[i].wr) `CHK("reg", ROWS[i].d, rd)
      `CHK("resp", ROWS[i].r, rsp)
    end
    `CHK("maskable_allow", 1'h1, core_out.maskable_allow)
    // Every edge choice with the inhibit and trap flags set; only selected edges are taken
    sload(32'h60);
    for (int s = 0; s < 4; s++) begin
      sel = 2'(s);
      wreg(OFF_RISE_SEL, {31'h0, sel[0]});
      wreg(OFF_FALL_SEL, {31'h0, sel[1]});
      for (int k = 1; k >= 0; k--) begin
        set_pin(k[0], 1'h0);
        wait_take(sel[1-k], NMI_HANDLER, 32'hA0);
        if (sel[1-k]) check_entry(32'h100, 32'h60);
        if (sel[1-k]) do_return(32'h100, 32'h60);
      end
    end
    // Requests arriving during service wait for the return
    wreg(OFF_WDT_MODE, {30'h0, WDT_MODE_NMI});
    wreg(OFF_FALL_SEL, 32'h0);
    set_pin(1'h1, 1'h0);
    wait_take(1'h1, NMI_HANDLER, 32'hA0);
    set_pin(1'h0, 1'h0);
    repeat (4) @(posedge aclk);
    set_pin(1'h1, 1'h1);
    wait_take(1'h0, NMI_HANDLER, 32'hA0);
    rchk(OFF_STATUS, 32'h7);
    do_return(32'h100, 32'h60);
    wait_take(1'h1, NMI_HANDLER, 32'hA0);
    check_entry(32'h100, 32'h60);
    rchk(OFF_STATUS, 32'h6);
    // Clearing the active flag lets the watchdog in at once
    sload(32'h20);
    wait_take(1'h1, NMI_HANDLER, 32'hA0);
    check_entry(32'h100, 32'h20);
    // Watchdog service ends with a system reset
    do_reset();
    @(posedge aclk);
    core_in.accept_ok <= 1'h0;
    wreg(OFF_WDT_MODE, 32'h1);
    set_pin(1'h0, 1'h1);
    repeat (4) @(posedge aclk);
    rchk(OFF_STATUS, 32'h0);
    wreg(OFF_WDT_MODE, {30'h0, WDT_MODE_NMI});
    wreg(OFF_FALL_SEL, 32'h1);
    set_pin(1'h1, 1'h0);
    repeat (4) @(posedge aclk);
    set_pin(1'h0, 1'h1);
    repeat (4) @(posedge aclk);
    rchk(OFF_STATUS, 32'h3);
    `CHK("maskable_allow", 1'h0, core_out.maskable_allow)
    @(posedge aclk);
    core_in.div_active <= 1'h1;
    core_in.div_pc <= 32'h200;
    core_in.accept_ok <= 1'h1;
    // Clock enable low freezes the unit: nothing is taken meanwhile
    ce <= 1'h0;
    wait_take(1'h0, NMI_HANDLER, 32'hA0);
    @(posedge aclk);
    ce <= 1'h1;
    wait_take(1'h1, NMI_HANDLER, 32'hA0);
    check_entry(32'h200, 32'h0);
    @(posedge aclk);
    core_in.div_active <= 1'h0;
    rchk(OFF_STATUS, 32'h6);
    do_return(32'h200, 32'h0);
    wait_take(1'h1, NMI_HANDLER, 32'hA0);
    finish_test();
  end
endmodule // nmu_unit_bench

`default_nettype wire
